// *** imm_pkg.sv ***
package imm_pkg;
   localparam int IMM_AW = 8;
   localparam int IMM_DW = 8;
   localparam logic [7:0] IMM_UPPER_BASE = 8'h80;
   localparam logic [7:0] IMM_SP_RESET = 8'h07;
   localparam logic [7:0] IMM_BIT_BYTE_BASE = 8'h20;
   localparam logic [7:0] IMM_SP_ADDR = 8'h81;
   localparam logic [7:0] IMM_PSW_ADDR = 8'hD0;
   localparam logic [7:0] IMM_NVD_ADRL_ADDR = 8'hC6;
   localparam logic [7:0] IMM_NVD_ADRH_ADDR = 8'hC7;
   localparam logic [7:0] IMM_NVD_DATA_ADDR = 8'hBC;
   localparam int IMM_NVD_BYTES = 640;
   localparam int IMM_PROG_BYTES = 8192;
   localparam int IMM_BANK_SHIFT = 3;
   localparam int IMM_RS_LSB = 3;

   // Access kinds issued by the core
   typedef enum logic [2:0] {
      IMM_DIRECT = 3'b000,
      IMM_INDIRECT = 3'b001,
      IMM_REGISTER = 3'b010,
      IMM_BIT = 3'b011,
      IMM_PUSH = 3'b100,
      IMM_POP = 3'b101
   } imm_mode_t;

   // One core request
   typedef struct packed {
      logic valid;
      logic write;
      imm_mode_t mode;
      logic [7:0] addr;
      logic [7:0] wdata;
   } imm_req_t;

   // One answer to the core
   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } imm_rsp_t;
endpackage : imm_pkg

// *** imm_core_mem.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - No external memory bus; code is fetched from internal 8-kByte store only.
// - Data space is lower RAM, upper RAM, register area, 640-byte array.
// - Upper RAM and register area share addresses; mode alone selects.
// - Lower RAM direct/indirect; upper RAM indirect only; registers direct only.
// - Nonvolatile data array reached only through address/data control registers.
// - Lowest 32 bytes are four banks of eight working registers.
// - Bytes 20H to 2FH also reachable as bits 00H to 7FH.
// - Stack may sit anywhere in internal data memory, up to 256 bytes.
// - Reset sets stack pointer to 07H; first push writes 08H.
module imm_core_mem
   import imm_pkg::*;
#(
   parameter int NVD_BYTES = IMM_NVD_BYTES,
   parameter int PROG_BYTES = IMM_PROG_BYTES
) (
   input wire logic clock,
   input wire logic nrst,
   input wire imm_req_t req,
   input wire logic [12:0] fetch_addr,
   input wire logic [7:0] prog_wdata,
   input wire logic prog_we,
   output imm_rsp_t rsp,
   output logic [7:0] fetch_data,
   output logic [7:0] sp
);
   ////////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [255:0][7:0] ram;
      logic [7:0] sp;
      logic [7:0] psw;
      logic [15:0] nvd_addr;
      imm_rsp_t rsp;
      logic [7:0] fetch;
   } imm_state_t;

   imm_state_t st;
   imm_state_t next_st;
   logic [NVD_BYTES-1:0][7:0] nvd;
   logic [PROG_BYTES-1:0][7:0] prog;
   logic [7:0] eff;
   logic is_upper;
   logic [9:0] nvd_idx;
   logic nvd_ok;
   logic [2:0] bit_pos;
   logic [7:0] bit_byte;
   logic [7:0] reg_rd;

   ////////////////////////////////////////////////////////////////////////////////
   // Address steering
   always_comb begin
      nvd_idx = st.nvd_addr[9:0];
      nvd_ok = st.nvd_addr < 16'(NVD_BYTES); // Whole address, no alias above 1K
      bit_byte = IMM_BIT_BYTE_BASE + {4'h0, req.addr[6:3]};
      bit_pos = req.addr[2:0];
      is_upper = req.addr >= IMM_UPPER_BASE;
      unique case (req.mode)
         IMM_REGISTER: eff = {3'h0, st.psw[IMM_RS_LSB +: 2], req.addr[2:0]};
         IMM_PUSH: eff = st.sp + 8'h01;
         IMM_POP: eff = st.sp;
         IMM_BIT: eff = bit_byte;
         default: eff = req.addr;
      endcase
   end

   // Register area read decode, direct only
   always_comb begin
      reg_rd = 8'h00;
      if (req.addr == IMM_SP_ADDR) reg_rd = st.sp;
      else if (req.addr == IMM_PSW_ADDR) reg_rd = st.psw;
      else if (req.addr == IMM_NVD_ADRL_ADDR) reg_rd = st.nvd_addr[7:0];
      else if (req.addr == IMM_NVD_ADRH_ADDR) reg_rd = st.nvd_addr[15:8];
      else if (req.addr == IMM_NVD_DATA_ADDR && nvd_ok) reg_rd = nvd[nvd_idx];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_st = st;
      next_st.rsp = '0;
      next_st.fetch = prog[fetch_addr];
      if (req.valid) begin
         next_st.rsp.valid = 1'b1;
         // Register area: direct only, unknown addresses read zero
         if (req.mode == IMM_DIRECT && is_upper) begin
            next_st.rsp.rdata = reg_rd;
            if (req.write) begin
               if (req.addr == IMM_SP_ADDR) next_st.sp = req.wdata;
               if (req.addr == IMM_PSW_ADDR) next_st.psw = req.wdata;
               if (req.addr == IMM_NVD_ADRL_ADDR) next_st.nvd_addr[7:0] = req.wdata;
               if (req.addr == IMM_NVD_ADRH_ADDR) next_st.nvd_addr[15:8] = req.wdata;
            end
         end else if (req.mode == IMM_BIT) begin
            // One bit of the bit area, answered in bit 0
            next_st.rsp.rdata = {7'h00, st.ram[eff][bit_pos]};
            if (req.write) next_st.ram[eff][bit_pos] = req.wdata[0];
         end else begin
            next_st.rsp.rdata = st.ram[eff];
            // Pop only reads, whatever its write flag says
            if ((req.write && req.mode != IMM_POP) || req.mode == IMM_PUSH) begin
               next_st.ram[eff] = req.wdata;
            end
            if (req.mode == IMM_PUSH) next_st.sp = eff;
            if (req.mode == IMM_POP) next_st.sp = st.sp - 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
         st.sp <= IMM_SP_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Nonvolatile stores, contents survive reset
   always_ff @(posedge clock) begin
      if (req.valid && req.write && req.mode == IMM_DIRECT
          && req.addr == IMM_NVD_DATA_ADDR && nvd_ok) begin
         nvd[nvd_idx] <= req.wdata;
      end
      if (prog_we) begin
         prog[fetch_addr] <= prog_wdata;
      end
   end

   assign rsp = st.rsp;
   assign fetch_data = st.fetch;
   assign sp = st.sp;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   // Stack pointer and stack traffic
   a_sp_reset_val: assert property (@(posedge clock) $rose(nrst) |-> sp == IMM_SP_RESET)
      else $error("stack pointer not 07H after reset");
   a_push_incr: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.mode == IMM_PUSH |=> sp == $past(sp) + 8'h01)
      else $error("push did not pre-increment");
   a_push_store: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.mode == IMM_PUSH |=> st.ram[sp] == $past(req.wdata))
      else $error("push data not at new stack top");
   a_pop_decr: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.mode == IMM_POP |=> sp == $past(sp) - 8'h01)
      else $error("pop did not post-decrement");
   a_pop_data: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.mode == IMM_POP |=> rsp.rdata == $past(st.ram[sp]))
      else $error("pop returned wrong byte");

   // Every access answered once, nothing answered unasked
   a_answer_next: assert property (@(posedge clock) disable iff (!nrst)
      req.valid |=> rsp.valid)
      else $error("access without answer");
   a_answer_only: assert property (@(posedge clock) disable iff (!nrst)
      !req.valid |=> !rsp.valid)
      else $error("answer without access");

   // Shared upper addresses, mode picks the place
   a_upper_ram_rt: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.write && req.mode == IMM_INDIRECT && is_upper ##1 !req.valid
      ##1 req.valid && !req.write && req.mode == IMM_INDIRECT && req.addr == $past(req.addr, 2)
      |=> rsp.rdata == $past(req.wdata, 3))
      else $error("upper RAM indirect readback wrong");
   a_direct_upper_keep: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.write && req.mode == IMM_DIRECT && is_upper
      |=> st.ram[$past(req.addr)] == $past(st.ram[req.addr]))
      else $error("direct write reached upper RAM");
   a_indirect_sp_keep: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.write && req.mode == IMM_INDIRECT |=> sp == $past(sp))
      else $error("indirect write reached register area");
   a_sfr_sp_read: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && !req.write && req.mode == IMM_DIRECT && req.addr == IMM_SP_ADDR
      |=> rsp.rdata == $past(sp))
      else $error("direct read of stack pointer wrong");
   a_psw_read: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && !req.write && req.mode == IMM_DIRECT && req.addr == IMM_PSW_ADDR
      |=> rsp.rdata == $past(st.psw))
      else $error("direct read of bank select wrong");
   a_lower_shared: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.write && req.mode == IMM_DIRECT && !is_upper
      |=> st.ram[$past(req.addr)] == $past(req.wdata))
      else $error("lower RAM direct write lost");
   a_ram_quiet: assert property (@(posedge clock) disable iff (!nrst)
      !req.valid |=> $stable(st.ram))
      else $error("RAM changed without access");

   // Working register banks and bit area
   a_bank_rt: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.write && req.mode == IMM_REGISTER
      |=> st.ram[{3'h0, $past(st.psw[IMM_RS_LSB +: 2]), $past(req.addr[2:0])}]
          == $past(req.wdata))
      else $error("bank register write misplaced");
   a_reg_read: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && !req.write && req.mode == IMM_REGISTER
      |=> rsp.rdata == $past(st.ram[{3'h0, st.psw[IMM_RS_LSB +: 2], req.addr[2:0]}]))
      else $error("bank register read wrong");
   a_bit_map: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.write && req.mode == IMM_BIT
      |=> st.ram[IMM_BIT_BYTE_BASE + $past(req.addr[6:3])][$past(req.addr[2:0])]
          == $past(req.wdata[0]))
      else $error("bit write misplaced");
   a_bit_read: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && !req.write && req.mode == IMM_BIT
      |=> rsp.rdata == {7'h00, $past(st.ram[IMM_BIT_BYTE_BASE + req.addr[6:3]][req.addr[2:0]])})
      else $error("bit read wrong");

   // Array reached only through its control registers
   a_nvd_addr_hold: assert property (@(posedge clock) disable iff (!nrst)
      !req.valid |=> $stable(st.nvd_addr))
      else $error("array address moved without access");
   a_nvd_addr_low: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.write && req.mode == IMM_DIRECT && req.addr == IMM_NVD_ADRL_ADDR
      |=> st.nvd_addr[7:0] == $past(req.wdata))
      else $error("array address low byte not loaded");
   a_nvd_addr_high: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && req.write && req.mode == IMM_DIRECT && req.addr == IMM_NVD_ADRH_ADDR
      |=> st.nvd_addr[15:8] == $past(req.wdata))
      else $error("array address high byte not loaded");
   a_nvd_out_zero: assert property (@(posedge clock) disable iff (!nrst)
      req.valid && !req.write && req.mode == IMM_DIRECT && req.addr == IMM_NVD_DATA_ADDR
      && !nvd_ok |=> rsp.rdata == 8'h00)
      else $error("read past the array end not zero");

   // Main scenarios
   c_push: cover property (@(posedge clock) req.valid && req.mode == IMM_PUSH);
   c_pop: cover property (@(posedge clock) req.valid && req.mode == IMM_POP);
   c_upper: cover property (@(posedge clock) req.valid && req.mode == IMM_INDIRECT && is_upper);
   c_bit: cover property (@(posedge clock) req.valid && req.mode == IMM_BIT);
   c_nvd: cover property (@(posedge clock) req.valid && req.addr == IMM_NVD_DATA_ADDR);
endmodule : imm_core_mem

// *** imm_core_bfm.sv ***
`timescale 1ns/1ps
// Core side: one access per call, strobe up for one cycle
module imm_core_bfm
   import imm_pkg::*;
(
   input wire logic clock,
   input wire imm_rsp_t rsp,
   output imm_req_t req
);
   initial req = '0;
   // Issue, release after the taking edge, read the answer 1 ns after that same edge
   task automatic access(input logic w, input imm_mode_t m, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge clock);
      req <= '{1'b1, w, m, a, d};
      @(posedge clock);
      req <= '0;
      #1;
      for (n = 0; n < 4 && rsp.valid !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      q = rsp.rdata;
      if (n == 4) begin
         tb_top.n_fail++;
         tb_top.give_verdict();
      end
   endtask : access
endmodule : imm_core_bfm

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import imm_pkg::*;
   logic clock, nrst, prog_we;
   logic [12:0] fetch_addr;
   logic [7:0] prog_wdata, q, fetch_data, sp;
   imm_req_t req;
   imm_rsp_t rsp;
   int n_fail = 0;
   int n_checks = 0;
   imm_core_mem u_imm_core_mem (.clock(clock), .nrst(nrst), .req(req), .fetch_addr(fetch_addr),
      .prog_wdata(prog_wdata), .prog_we(prog_we), .rsp(rsp), .fetch_data(fetch_data), .sp(sp));
   imm_core_bfm u_imm_core_bfm (.clock(clock), .rsp(rsp), .req(req));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic give_verdict();
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   // Compare one byte
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input imm_mode_t m, input logic [7:0] a, input logic [7:0] d);
      u_imm_core_bfm.access(w, m, a, d, q);
   endtask : acc
   ////////////////////////////////////////////////////////////////////////////
   // Stack from reset, push then pop
   task automatic t_stack();
      chk(sp, 8'h07);
      acc(1'b1, IMM_PUSH, 8'h00, 8'hA5);
      chk(sp, 8'h08);
      acc(1'b0, IMM_INDIRECT, 8'h08, 8'h00);
      chk(q, 8'hA5);
      acc(1'b0, IMM_POP, 8'h00, 8'h00);
      chk(q, 8'hA5);
      chk(sp, 8'h07);
   endtask : t_stack
   // Same address, mode picks the place
   task automatic t_split();
      acc(1'b1, IMM_INDIRECT, 8'h90, 8'h3C);
      acc(1'b1, IMM_DIRECT, 8'h90, 8'hFF);
      acc(1'b0, IMM_DIRECT, 8'h90, 8'h00);
      chk(q, 8'h00);
      acc(1'b0, IMM_INDIRECT, 8'h90, 8'h00);
      chk(q, 8'h3C);
      acc(1'b1, IMM_DIRECT, 8'h7F, 8'h5A);
      acc(1'b0, IMM_INDIRECT, 8'h7F, 8'h00);
      chk(q, 8'h5A);
      acc(1'b1, IMM_INDIRECT, 8'hA0, 8'h5C);
      acc(1'b0, IMM_INDIRECT, 8'hA0, 8'h00);
      chk(q, 8'h5C);
      acc(1'b1, IMM_DIRECT, IMM_SP_ADDR, 8'hC0);
      acc(1'b1, IMM_PUSH, 8'h00, 8'h11);
      acc(1'b0, IMM_INDIRECT, 8'hC1, 8'h00);
      chk(q, 8'h11);
      acc(1'b0, IMM_DIRECT, IMM_SP_ADDR, 8'h00);
      chk(q, 8'hC1);
   endtask : t_split
   // Working registers of bank two, top bit of the bit area
   task automatic t_bank_bit();
      acc(1'b1, IMM_DIRECT, IMM_PSW_ADDR, 8'h10);
      acc(1'b0, IMM_DIRECT, IMM_PSW_ADDR, 8'h00);
      chk(q, 8'h10);
      acc(1'b1, IMM_REGISTER, 8'h03, 8'h77);
      acc(1'b0, IMM_INDIRECT, 8'h13, 8'h00);
      chk(q, 8'h77);
      acc(1'b0, IMM_REGISTER, 8'h03, 8'h00);
      chk(q, 8'h77);
      acc(1'b1, IMM_BIT, 8'h7F, 8'h01);
      acc(1'b0, IMM_DIRECT, 8'h2F, 8'h00);
      chk(q, 8'h80);
      acc(1'b0, IMM_BIT, 8'h7F, 8'h00);
      chk(q, 8'h01);
   endtask : t_bank_bit
   // Last array byte, then one past the end
   task automatic t_array();
      acc(1'b1, IMM_DIRECT, IMM_NVD_ADRL_ADDR, 8'h7F);
      acc(1'b1, IMM_DIRECT, IMM_NVD_ADRH_ADDR, 8'h02);
      acc(1'b1, IMM_DIRECT, IMM_NVD_DATA_ADDR, 8'h96);
      acc(1'b0, IMM_DIRECT, IMM_NVD_DATA_ADDR, 8'h00);
      chk(q, 8'h96);
      acc(1'b1, IMM_DIRECT, IMM_NVD_ADRL_ADDR, 8'h80);
      acc(1'b0, IMM_DIRECT, IMM_NVD_DATA_ADDR, 8'h00);
      chk(q, 8'h00);
   endtask : t_array
   // Load the top code byte and fetch it back
   task automatic t_code();
      @(posedge clock);
      fetch_addr <= 13'h1FFF;
      prog_wdata <= 8'hE1;
      prog_we <= 1'b1;
      @(posedge clock);
      prog_we <= 1'b0;
      @(posedge clock);
      #1;
      chk(fetch_data, 8'hE1);
   endtask : t_code
   // Reset in mid-run: stack restarts, array contents survive
   task automatic t_rerun();
      @(posedge clock);
      nrst <= 1'b0;
      @(posedge clock);
      nrst <= 1'b1;
      #1;
      chk(sp, 8'h07);
      acc(1'b1, IMM_PUSH, 8'h00, 8'h3E);
      chk(sp, 8'h08);
      acc(1'b0, IMM_DIRECT, 8'h08, 8'h00);
      chk(q, 8'h3E);
      acc(1'b1, IMM_DIRECT, IMM_NVD_ADRL_ADDR, 8'h7F);
      acc(1'b1, IMM_DIRECT, IMM_NVD_ADRH_ADDR, 8'h02);
      acc(1'b0, IMM_DIRECT, IMM_NVD_DATA_ADDR, 8'h00);
      chk(q, 8'h96);
   endtask : t_rerun
   initial begin
      nrst = 1'b0;
      prog_we = 1'b0;
      fetch_addr = '0;
      prog_wdata = '0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      t_stack();
      t_split();
      t_bank_bit();
      t_array();
      t_code();
      t_rerun();
      give_verdict();
   end
endmodule : tb_top
